// ==== hw/clk_switch_pkg.sv ====
// Constants and decode helpers for the clock switch and prescaler
package clk_switch_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] SRC_SEL_OFS = 8'h00;
  localparam logic [7:0] CMD_OFS = 8'h04;
  localparam logic [7:0] PRESC_OFS = 8'h08;
  localparam logic [7:0] MCU_CTRL_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  // ==========================================================
  // Field values and reset values
  localparam logic [7:0] CHG_EN_ONLY = 8'h80;
  localparam logic [3:0] CMD_DISABLE = 4'h1;
  localparam logic [3:0] CMD_ENABLE = 4'h2;
  localparam logic [3:0] CMD_REQUEST = 4'h3;
  localparam logic [3:0] CMD_SWITCH = 4'h4;
  localparam logic [3:0] CMD_RECOVER = 4'h5;
  localparam logic [3:0] DIV_DEF = 4'h0;
  localparam logic [3:0] DIV_FUSED = 4'h3;
  localparam logic [3:0] DIV_MAX = 4'h8;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // ==========================================================
  // Timing: protection window in cycles, ready counts in edges
  localparam logic [2:0] PROT_CYCLES = 3'h4;
  localparam logic [14:0] RDY_CNT_0 = 15'h0006;
  localparam logic [14:0] RDY_CNT_1 = 15'h0102;
  localparam logic [14:0] RDY_CNT_2 = 15'h0400;
  // ==========================================================
  // Clock source classes
  localparam int NCLS = 5;
  localparam logic [2:0] CLS_RC = 3'h0;
  localparam logic [2:0] CLS_WDT = 3'h1;
  localparam logic [2:0] CLS_EXT = 3'h2;
  localparam logic [2:0] CLS_XTAL = 3'h3;
  localparam logic [2:0] CLS_PLL = 3'h4;
  localparam logic [2:0] CLS_NONE = 3'h7;
  localparam logic [3:0] CODE_RC8 = 4'h2;
  typedef enum logic [1:0] {
    INIT_A = 2'b00,
    INIT_B = 2'b01,
    INIT_LOAD = 2'b11,
    RUN = 2'b10
  } init_state_t;

  // Map a source code to its oscillator class
  function automatic logic [2:0] src_class(input logic [3:0] code);
    case (code)
      4'h0: src_class = CLS_EXT;
      4'h1, 4'h4, 4'h5: src_class = CLS_PLL;
      4'h2, 4'h6: src_class = CLS_RC;
      4'h3: src_class = CLS_WDT;
      4'h7: src_class = CLS_NONE;
      default: src_class = CLS_XTAL;
    endcase
  endfunction

  // Reference class of a PLL source code
  function automatic logic [2:0] pll_ref_of(input logic [3:0] code);
    case (code)
      4'h1: pll_ref_of = CLS_RC;
      4'h4: pll_ref_of = CLS_XTAL;
      4'h5: pll_ref_of = CLS_EXT;
      default: pll_ref_of = CLS_NONE;
    endcase
  endfunction
endpackage

// ==== hw/clk_prescaler.sv ====
// Glitch-free power-of-two system clock prescaler
`timescale 1ns/1ps
module clk_prescaler
  import clk_switch_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Division control and divided tick
  input wire logic [3:0] div_sel,
  output logic clk_tick
);
  // ==========================================================
  // Counter
  logic [7:0] cnt_r, cnt_nxt;
  logic [3:0] act_r, act_nxt;
  logic tick_r, tick_nxt;
  logic [7:0] last;

  // New division only taken at the end of a whole old period
  always_comb
  begin
    last = 8'(({8'h0, 8'h1} << act_r) - 16'h1);
    if (cnt_r == last) // [R17] [R18]
    begin
      cnt_nxt = 8'h0;
      act_nxt = div_sel;
      tick_nxt = 1'b1;
    end
    else
    begin
      cnt_nxt = 8'(cnt_r + 8'h1);
      act_nxt = act_r;
      tick_nxt = 1'b0;
    end
  end

  // Counter runs on the undivided clock, state is not visible
  always_ff @(posedge hclk or negedge hresetn) // [R19]
  begin
    if (!hresetn)
    begin
      cnt_r <= 8'h0;
      act_r <= 4'h0;
      tick_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      act_r <= act_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign clk_tick = tick_r; // [R16]

  // ==========================================================
  // Checks
  property p_no_fast;
    @(posedge hclk) disable iff (!hresetn)
    clk_tick && act_r != 4'h0 |=> !clk_tick;
  endproperty
  a_no_fast: assert property (p_no_fast) // [R17]
    else $error("prescaler tick faster than setting");
endmodule // clk_prescaler

// ==== hw/clk_switch.sv ====
// Clock source switch, command decode and prescaler control registers
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
// ============================================================
// Overview of operation
// R1: Reset loads source code, start-up and clock-out from low fuse byte.
// R2: Commands need change-enable write first, then command write.
// R3: Decode commands 1 disable, 2 enable, 3 request, 4 switch, 5 recover.
// R4: Enable, disable, request and switch latch config per source.
// R5: Recover writes current system source code, nothing else.
// R6: Several sources may be enabled at once.
// R7: Enable starts selected source with its start-up setting.
// R8: Disable ignored when target drives the system clock.
// R9: Request clears ready, counts source edges, then sets ready.
// R10: Software keeps source and start-up fields still while counting.
// R11: Software checks new source, switches, then disables old one.
// R12: Five sources: RC, watchdog, external, crystal, PLL divided.
// R13: Only one external source enabled; no direct ext/xtal switch.
// R14: PLL reference cannot change while PLL drives system clock.
// R15: RC to RC frequency change only via RC frequency bit.
// R16: Prescaler divides the system clocks by programmed factor.
// R17: Division changes give no glitch and no faster clock.
// R18: New division takes effect after old plus new periods.
// R19: Prescaler counter runs on undivided clock, not readable.
// R20: Prescaler change-enable then value within four cycles.
// R21: Division is two to the power of code, up to 256.
// R22: Reset division is eight when fuse set, else one.
// R23: Command change-enable also expires after four cycles.
module clk_switch
  import clk_switch_pkg::*;
#(
  parameter logic [14:0] RDY_CNT_LONG = 15'h4000
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Fuses and oscillator activity
  input wire logic [7:0] fuse_low,
  input wire logic div_by_eight_fuse,
  input wire logic [4:0] osc_raw,
  // Clock tree controls
  output logic [4:0] osc_enable,
  output logic [2:0] pll_ref_class,
  output logic [3:0] sys_src_code,
  output logic [1:0] sys_startup,
  output logic clk_out_enable,
  output logic rc_freq_select,
  output logic sys_clk_tick
);
  // ==========================================================
  // State declarations
  init_state_t state_r, state_nxt;
  logic [8:0] fuse_s1_r, fuse_s2_r;
  logic [4:0] osc_s1_r, osc_s2_r, osc_s3_r;
  logic [3:0] src_code_r, src_code_nxt;
  logic [1:0] sut_r, sut_nxt;
  logic clock_out_enable_bit_r, clock_out_enable_bit_nxt;
  logic cce_r, cce_nxt, pce_r, pce_nxt;
  logic [2:0] cce_cnt_r, cce_cnt_nxt, pce_cnt_r, pce_cnt_nxt;
  logic rdy_r, rdy_nxt, counting_r, counting_nxt;
  logic [14:0] cnt_r, cnt_nxt, len_r, len_nxt;
  logic [2:0] cnt_cls_r, cnt_cls_nxt;
  logic [3:0] div_r, div_nxt;
  logic rc_r, rc_nxt;
  logic [4:0] en_r, en_nxt;
  logic [3:0] cur_code_r, cur_code_nxt;
  logic [2:0] pll_ref_r, pll_ref_nxt;
  logic [1:0] sut_mem_r [NCLS];
  logic [1:0] sut_mem_nxt [NCLS];
  logic clock_out_enable_bit_mem_r [NCLS];
  logic clock_out_enable_bit_mem_nxt [NCLS];
  logic [1:0] out_sut_r, out_sut_nxt;
  logic out_clock_out_enable_bit_r, out_clock_out_enable_bit_nxt;
  logic [2:0] cls, cur_cls, ref_cls, base_cls, nxt_cls;
  logic [4:0] osc_edge;
  logic [7:0] wd;
  logic cmd_go, cnt_start, ext_clash, pll_lock;

  // Ready count length for a start-up code
  function automatic logic [14:0] rdy_len(input logic [1:0] sut);
    case (sut)
      2'h0: rdy_len = RDY_CNT_0;
      2'h1: rdy_len = RDY_CNT_1;
      2'h2: rdy_len = RDY_CNT_2;
      default: rdy_len = RDY_CNT_LONG;
    endcase
  endfunction

  // ==========================================================
  // Bus slave: zero wait, reads registered into the data phase
  logic addr_ok, wr_pend_r, wr_pend_nxt;
  logic [7:0] wr_addr_r, wr_addr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;

  always_comb
  begin
    addr_ok = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
    wr_pend_nxt = addr_ok && hwrite;
    wr_addr_nxt = haddr;
    hrdata_nxt = 32'h0;
    if (addr_ok && !hwrite)
    begin
      case (haddr)
        SRC_SEL_OFS: hrdata_nxt = {25'h0, clock_out_enable_bit_r, sut_r, src_code_r};
        CMD_OFS: hrdata_nxt = {24'h0, cce_r, 2'h0, rdy_r, 4'h0};
        PRESC_OFS: hrdata_nxt = {24'h0, pce_r, 3'h0, div_r};
        MCU_CTRL_OFS: hrdata_nxt = {31'h0, rc_r};
        STATUS_OFS: hrdata_nxt = {19'h0, en_r, 1'h0, pll_ref_r,
                                  cur_code_r};
        default: hrdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h0;
      hrdata_r <= 32'h0;
    end
    else
    begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ==========================================================
  // Control next state: fuse load, protection, commands, counting
  always_comb
  begin
    state_nxt = state_r;
    src_code_nxt = src_code_r;
    sut_nxt = sut_r;
    clock_out_enable_bit_nxt = clock_out_enable_bit_r;
    cce_nxt = cce_r;
    cce_cnt_nxt = cce_cnt_r;
    pce_nxt = pce_r;
    pce_cnt_nxt = pce_cnt_r;
    rdy_nxt = rdy_r;
    counting_nxt = counting_r;
    cnt_nxt = cnt_r;
    len_nxt = len_r;
    cnt_cls_nxt = cnt_cls_r;
    div_nxt = div_r;
    rc_nxt = rc_r;
    en_nxt = en_r;
    cur_code_nxt = cur_code_r;
    pll_ref_nxt = pll_ref_r;
    sut_mem_nxt = sut_mem_r;
    clock_out_enable_bit_mem_nxt = clock_out_enable_bit_mem_r;
    wd = hwdata[7:0];
    cls = src_class(src_code_r);
    cur_cls = src_class(cur_code_r);
    ref_cls = pll_ref_of(src_code_r);
    base_cls = (cls == CLS_PLL) ? ref_cls : cls;
    ext_clash = (base_cls == CLS_EXT && en_r[CLS_XTAL]) ||
                (base_cls == CLS_XTAL && en_r[CLS_EXT]); // [R13]
    pll_lock = cls == CLS_PLL && cur_cls == CLS_PLL &&
               ref_cls != pll_ref_r; // [R14]
    osc_edge = osc_s2_r & ~osc_s3_r;
    cmd_go = 1'b0;
    cnt_start = 1'b0;
    // Protection windows expire after four cycles
    if (cce_r)
    begin
      cce_cnt_nxt = 3'(cce_cnt_r - 3'h1);
      cce_nxt = cce_cnt_r != 3'h1; // [R23]
    end
    if (pce_r)
    begin
      pce_cnt_nxt = 3'(pce_cnt_r - 3'h1);
      pce_nxt = pce_cnt_r != 3'h1; // [R20]
    end
    // Availability count over the selected source's edges
    if (counting_r && cnt_cls_r != CLS_NONE && osc_edge[cnt_cls_r])
    begin
      cnt_nxt = 15'(cnt_r + 15'h1);
      if (15'(cnt_r + 15'h1) == len_r)
      begin
        counting_nxt = 1'b0;
        rdy_nxt = 1'b1; // [R9]
      end
    end
    case (state_r)
      INIT_A: state_nxt = INIT_B;
      INIT_B: state_nxt = INIT_LOAD;
      INIT_LOAD:
      begin
        state_nxt = RUN;
        src_code_nxt = fuse_s2_r[3:0]; // [R1]
        sut_nxt = fuse_s2_r[5:4];
        clock_out_enable_bit_nxt = fuse_s2_r[6];
        cur_code_nxt = fuse_s2_r[3:0];
        nxt_cls = src_class(fuse_s2_r[3:0]);
        pll_ref_nxt = pll_ref_of(fuse_s2_r[3:0]);
        if (nxt_cls != CLS_NONE)
        begin
          en_nxt[nxt_cls] = 1'b1;
          sut_mem_nxt[nxt_cls] = fuse_s2_r[5:4];
          clock_out_enable_bit_mem_nxt[nxt_cls] = fuse_s2_r[6];
        end
        if (pll_ref_nxt != CLS_NONE)
          en_nxt[pll_ref_nxt] = 1'b1;
        div_nxt = fuse_s2_r[8] ? DIV_FUSED : DIV_DEF; // [R22]
      end
      RUN:
      begin
        if (wr_pend_r)
        begin
          case (wr_addr_r)
            SRC_SEL_OFS:
            begin
              src_code_nxt = wd[3:0];
              sut_nxt = wd[5:4];
              clock_out_enable_bit_nxt = wd[6];
            end
            CMD_OFS:
            begin
              if (wd == CHG_EN_ONLY && !cce_r)
              begin
                cce_nxt = 1'b1; // [R2]
                cce_cnt_nxt = PROT_CYCLES;
              end
              else if (!wd[7] && cce_r)
              begin
                cce_nxt = 1'b0;
                cmd_go = 1'b1; // [R2]
              end
            end
            PRESC_OFS:
            begin
              if (wd == CHG_EN_ONLY && !pce_r)
              begin
                pce_nxt = 1'b1; // [R20]
                pce_cnt_nxt = PROT_CYCLES;
              end
              else if (!wd[7] && pce_r)
              begin
                pce_nxt = 1'b0;
                if (wd[3:0] <= DIV_MAX) // [R21]
                  div_nxt = wd[3:0];
              end
            end
            MCU_CTRL_OFS: rc_nxt = wd[0]; // [R15]
            default: rc_nxt = rc_r;
          endcase
        end
        if (cmd_go && cls != CLS_NONE) // [R3]
        begin
          case (wd[3:0])
            CMD_DISABLE:
              if (cls != cur_cls &&
                  !(cur_cls == CLS_PLL && cls == pll_ref_r)) // [R8]
                en_nxt[cls] = 1'b0;
            CMD_ENABLE:
              if (!ext_clash && !pll_lock) // [R6] [R7]
              begin
                en_nxt[cls] = 1'b1;
                if (cls == CLS_PLL)
                begin
                  en_nxt[ref_cls] = 1'b1;
                  pll_ref_nxt = ref_cls;
                end
              end
            CMD_REQUEST:
            begin
              cnt_start = 1'b1;
              rdy_nxt = 1'b0; // [R9]
              counting_nxt = 1'b1;
              cnt_nxt = 15'h0;
              cnt_cls_nxt = cls;
              len_nxt = rdy_len(sut_r);
            end
            CMD_SWITCH:
              if (en_r[cls] && !pll_lock && // [R12] [R14]
                  !(cur_cls == CLS_EXT && cls == CLS_XTAL) &&
                  !(cur_cls == CLS_XTAL && cls == CLS_EXT) && // [R13]
                  !(cur_cls == CLS_RC && cls == CLS_RC)) // [R15]
                cur_code_nxt = src_code_r;
            default: cur_code_nxt = cur_code_r;
          endcase
          if (wd[3:0] != CMD_RECOVER)
          begin
            sut_mem_nxt[cls] = sut_r; // [R4]
            clock_out_enable_bit_mem_nxt[cls] = clock_out_enable_bit_r;
          end
        end
        if (cmd_go && wd[3:0] == CMD_RECOVER)
          src_code_nxt = cur_code_r; // [R5]
      end
      default: state_nxt = INIT_A;
    endcase
    nxt_cls = src_class(cur_code_nxt);
    out_sut_nxt = (nxt_cls == CLS_NONE) ? 2'h0 : sut_mem_nxt[nxt_cls];
    out_clock_out_enable_bit_nxt = (nxt_cls != CLS_NONE) && clock_out_enable_bit_mem_nxt[nxt_cls];
  end

  // Register control state; pins pass two flops first
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= INIT_A;
      {fuse_s1_r, fuse_s2_r} <= 18'h0;
      {osc_s1_r, osc_s2_r, osc_s3_r} <= 15'h0;
      {src_code_r, sut_r, clock_out_enable_bit_r} <= 7'h0;
      {cce_r, cce_cnt_r, pce_r, pce_cnt_r} <= 8'h0;
      {rdy_r, counting_r, cnt_cls_r} <= 5'h0;
      {cnt_r, len_r} <= 30'h0;
      {div_r, rc_r, en_r} <= 10'h0;
      {cur_code_r, pll_ref_r} <= 7'h0;
      sut_mem_r <= '{default: 2'h0};
      clock_out_enable_bit_mem_r <= '{default: 1'b0};
      {out_sut_r, out_clock_out_enable_bit_r} <= 3'h0;
    end
    else
    begin
      state_r <= state_nxt;
      fuse_s1_r <= {div_by_eight_fuse, fuse_low};
      fuse_s2_r <= fuse_s1_r;
      osc_s1_r <= osc_raw;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
      {src_code_r, sut_r, clock_out_enable_bit_r} <= {src_code_nxt, sut_nxt, clock_out_enable_bit_nxt};
      {cce_r, cce_cnt_r} <= {cce_nxt, cce_cnt_nxt};
      {pce_r, pce_cnt_r} <= {pce_nxt, pce_cnt_nxt};
      {rdy_r, counting_r, cnt_cls_r} <= {rdy_nxt, counting_nxt,
                                         cnt_cls_nxt};
      {cnt_r, len_r} <= {cnt_nxt, len_nxt};
      {div_r, rc_r, en_r} <= {div_nxt, rc_nxt, en_nxt};
      {cur_code_r, pll_ref_r} <= {cur_code_nxt, pll_ref_nxt};
      sut_mem_r <= sut_mem_nxt;
      clock_out_enable_bit_mem_r <= clock_out_enable_bit_mem_nxt;
      {out_sut_r, out_clock_out_enable_bit_r} <= {out_sut_nxt, out_clock_out_enable_bit_nxt};
    end
  end

  // ==========================================================
  // Outputs and prescaler
  assign osc_enable = en_r;
  assign pll_ref_class = pll_ref_r;
  assign sys_src_code = cur_code_r;
  assign sys_startup = out_sut_r;
  assign clk_out_enable = out_clock_out_enable_bit_r;
  assign rc_freq_select = rc_r;

  clk_prescaler u_presc (
    .hclk(hclk),
    .hresetn(hresetn),
    .div_sel(div_r), // [R16]
    .clk_tick(sys_clk_tick)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_fuse_load;
    state_r == INIT_LOAD |=> src_code_r == $past(fuse_s2_r[3:0]) &&
      cur_code_r == src_code_r;
  endproperty
  a_fuse_load: assert property (p_fuse_load) // [R1]
    else $error("fuse source code not loaded");
  property p_cmd_window;
    $rose(cce_r) |-> ##[1:4] !cce_r;
  endproperty
  a_cmd_window: assert property (p_cmd_window) // [R23]
    else $error("command change enable outlived window");
  property p_presc_window;
    $rose(pce_r) |-> ##[1:4] !pce_r;
  endproperty
  a_presc_window: assert property (p_presc_window) // [R20]
    else $error("prescaler change enable outlived window");
  property p_div_range;
    div_r <= DIV_MAX;
  endproperty
  a_div_range: assert property (p_div_range) // [R21]
    else $error("reserved division code stored");
  property p_cur_enabled;
    state_r == RUN && cur_cls != CLS_NONE |-> en_r[cur_cls];
  endproperty
  a_cur_enabled: assert property (p_cur_enabled) // [R8]
    else $error("system clock source was disabled");
  property p_one_ext;
    !(en_r[CLS_EXT] && en_r[CLS_XTAL]);
  endproperty
  a_one_ext: assert property (p_one_ext) // [R13]
    else $error("external clock and crystal both enabled");
  property p_rdy_start;
    cnt_start |=> !rdy_r && counting_r ##1 !rdy_r || !counting_r;
  endproperty
  a_rdy_start: assert property (p_rdy_start) // [R9]
    else $error("ready not cleared at count start");
  property p_recover;
    cmd_go && wd[3:0] == CMD_RECOVER |=>
      src_code_r == $past(cur_code_r) && sut_r == $past(sut_r);
  endproperty
  a_recover: assert property (p_recover) // [R5]
    else $error("recover did not return system source");
  property p_pll_ref;
    cur_cls == CLS_PLL && $past(cur_cls) == CLS_PLL |->
      $stable(pll_ref_r);
  endproperty
  a_pll_ref: assert property (p_pll_ref) // [R14]
    else $error("PLL reference changed under PLL clock");
  c_ready: cover property (counting_r ##1 rdy_r);
  c_switch: cover property (cmd_go && wd[3:0] == CMD_SWITCH);
  c_recover: cover property (cmd_go && wd[3:0] == CMD_RECOVER);
  c_div: cover property ($changed(div_r) && state_r == RUN);
endmodule // clk_switch

// ==== tb/clk_switch_tb_top.sv ====
// Self-checking bench for the clock switch and prescaler over AHB-Lite
`timescale 1ns/1ps
module clk_switch_tb_top;
  import clk_switch_pkg::*;
  // ==========================================================
  // Signals and bookkeeping
  typedef struct {string nm; logic [31:0] exp; logic [31:0] msk;} note_t;
  localparam logic [14:0] RDY_LONG = 15'h0010;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rd_dp;
  logic div_by_eight_fuse, clk_out_enable, rc_freq_select, sys_clk_tick;
  logic [7:0] haddr, fuse_low;
  logic [1:0] htrans, sys_startup;
  logic [2:0] hsize, pll_ref_class;
  logic [31:0] hwdata, hrdata, r;
  logic [4:0] osc_raw, osc_enable;
  logic [3:0] sys_src_code;
  note_t q[$];
  note_t e;
  int miscompares, cmp_count, g, mn, prev, n;

  // Device under test, bus ready looped back from the one slave
  clk_switch #(.RDY_CNT_LONG(RDY_LONG)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .fuse_low(fuse_low),
    .div_by_eight_fuse(div_by_eight_fuse), .osc_raw(osc_raw),
    .osc_enable(osc_enable), .pll_ref_class(pll_ref_class),
    .sys_src_code(sys_src_code), .sys_startup(sys_startup),
    .clk_out_enable(clk_out_enable), .rc_freq_select(rc_freq_select),
    .sys_clk_tick(sys_clk_tick)
  );

  // ==========================================================
  // Clock, oscillator activity and watchdog
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Every oscillator toggles each two cycles, period of four
  initial
  begin
    osc_raw = 5'h00;
    forever
    begin
      repeat (2) @(posedge hclk);
      osc_raw <= ~osc_raw;
    end
  end

  // Cuts a hang short
  initial
  begin
    repeat (30000) @(posedge hclk);
    miscompares++;
    stop_test();
  end

  // ==========================================================
  // Comparison, verdict and bus tasks
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One single transfer: address phase, then data phase
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  // Read whose masked data the monitor compares with the note
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic [31:0] m, input string nm);
    q.push_back('{nm, x, m});
    bus(a, 1'b0, 32'h0);
  endtask

  // Protected command: change-enable first, then the code
  task automatic cmd(input logic [3:0] c);
    wr(CMD_OFS, {24'h0, CHG_EN_ONLY});
    wr(CMD_OFS, {28'h0, c});
  endtask

  // Cycles up to the next divided tick, sampled at falling edges
  task automatic gap(output int k);
    k = 0;
    do
    begin
      @(negedge hclk);
      k++;
    end
    while (sys_clk_tick !== 1'b1 && k < 600);
  endtask

  task automatic settle();
    repeat (2) @(negedge hclk);
  endtask

  function automatic int rdy_n(input int s);
    case (s)
      0: rdy_n = int'(RDY_CNT_0);
      1: rdy_n = int'(RDY_CNT_1);
      2: rdy_n = int'(RDY_CNT_2);
      default: rdy_n = int'(RDY_LONG);
    endcase
  endfunction

  // ==========================================================
  // Monitor: data phase of a read takes the oldest note
  always @(posedge hclk)
  begin
    if (rd_dp)
    begin
      e = q.pop_front();
      chk(e.nm, hrdata & e.msk, e.exp);
    end
    rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    r = $urandom(32'ha4f8);
    r = $urandom;
    rd_dp = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    fuse_low = {1'b0, r[6:4], CODE_RC8};
    div_by_eight_fuse = r[7];
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    // Fuse defaults and an unmapped place
    rd(SRC_SEL_OFS, {25'h0, fuse_low[6:0]}, 32'h7f, "src_sel");
    rd(PRESC_OFS, {28'h0, r[7] ? DIV_FUSED : DIV_DEF}, 32'hff, "div");
    rd(STATUS_OFS, 32'h0102, 32'h1f0f, "status");
    rd(8'h1c, 32'h0, 32'hffffffff, "unmapped");
    // Every division code, periods before and after each change
    prev = r[7] ? 8 : 1;
    for (int c = 0; c <= 8; c++)
    begin
      wr(PRESC_OFS, {24'h0, CHG_EN_ONLY});
      wr(PRESC_OFS, 32'(c));
      rd(PRESC_OFS, 32'(c), 32'hff, "div_set");
      mn = (1 << c) < prev ? (1 << c) : prev;
      gap(g);
      gap(g);
      chk("no_fast", 32'(g >= mn), 32'h1);
      gap(g);
      gap(g);
      chk("period", 32'(g), 32'(1 << c));
      prev = 1 << c;
      @(posedge hclk);
    end
    // Reserved code, unprotected write, expired window
    wr(PRESC_OFS, 32'h80);
    wr(PRESC_OFS, 32'h9);
    rd(PRESC_OFS, 32'h8, 32'hff, "div_rsv");
    wr(PRESC_OFS, 32'h2);
    rd(PRESC_OFS, 32'h8, 32'hff, "div_unprot");
    wr(PRESC_OFS, 32'h80);
    repeat (6) @(posedge hclk);
    wr(PRESC_OFS, 32'h2);
    rd(PRESC_OFS, 32'h8, 32'hff, "div_late");
    // Enable the watchdog beside the RC source
    wr(SRC_SEL_OFS, 32'h03);
    cmd(CMD_ENABLE);
    rd(STATUS_OFS, 32'h0302, 32'h1f0f, "enables");
    // Availability counts for every start-up code
    for (int s = 0; s < 4; s++)
    begin
      n = rdy_n(s);
      wr(SRC_SEL_OFS, 32'(s * 16 + 3));
      cmd(CMD_REQUEST);
      rd(CMD_OFS, 32'h0, 32'h10, "rdy_clr");
      repeat (n * 2) @(posedge hclk);
      rd(CMD_OFS, 32'h0, 32'h10, "rdy_early");
      repeat (n * 2 + 40) @(posedge hclk);
      rd(CMD_OFS, 32'h10, 32'h10, "rdy_set");
    end
    // Same watchdog source, now with clock-out set for the latch
    wr(SRC_SEL_OFS, 32'h73);
    // Switch refused without or after the protection window
    wr(CMD_OFS, {28'h0, CMD_SWITCH});
    settle();
    chk("sw_unprot", {28'h0, sys_src_code}, {28'h0, CODE_RC8});
    @(posedge hclk);
    wr(CMD_OFS, 32'h80);
    repeat (6) @(posedge hclk);
    wr(CMD_OFS, {28'h0, CMD_SWITCH});
    settle();
    chk("sw_late", {28'h0, sys_src_code}, {28'h0, CODE_RC8});
    @(posedge hclk);
    cmd(CMD_SWITCH);
    settle();
    chk("sw_done", {28'h0, sys_src_code}, 32'h3);
    chk("sw_sut", {30'h0, sys_startup}, 32'h3);
    chk("sw_clock_out_enable_bit", {31'h0, clk_out_enable}, 32'h1);
    @(posedge hclk);
    // Recover current code, then disable current (refused) and old source (done)
    wr(SRC_SEL_OFS, 32'h32);
    cmd(CMD_RECOVER);
    rd(SRC_SEL_OFS, 32'h3, 32'hf, "recover");
    wr(SRC_SEL_OFS, 32'h03);
    cmd(CMD_DISABLE);
    rd(STATUS_OFS, 32'h0303, 32'h1f0f, "dis_cur");
    wr(SRC_SEL_OFS, 32'h02);
    cmd(CMD_DISABLE);
    rd(STATUS_OFS, 32'h0203, 32'h1f0f, "dis_old");
    // Only one external source at a time
    wr(SRC_SEL_OFS, 32'h00);
    cmd(CMD_ENABLE);
    wr(SRC_SEL_OFS, 32'h08);
    cmd(CMD_ENABLE);
    rd(STATUS_OFS, 32'h0603, 32'h1f0f, "ext_only");
    // PLL on RC reference drives the clock, reference change refused
    wr(SRC_SEL_OFS, 32'h01);
    cmd(CMD_ENABLE);
    cmd(CMD_SWITCH);
    wr(SRC_SEL_OFS, 32'h05);
    cmd(CMD_ENABLE);
    rd(STATUS_OFS, 32'h1701, 32'h1f7f, "pll_lock");
    // RC frequency bit and the remaining output pins
    wr(MCU_CTRL_OFS, 32'h1);
    rd(MCU_CTRL_OFS, 32'h1, 32'h1, "rc_sel");
    chk("rc_pin", {31'h0, rc_freq_select}, 32'h1);
    chk("osc_en", {27'h0, osc_enable}, 32'h17);
    chk("pll_ref", {29'h0, pll_ref_class}, {29'h0, CLS_RC});
    chk("pll_cur", {28'h0, sys_src_code}, 32'h1);
    chk("hresp", {31'h0, hresp}, 32'h0);
    repeat (4) @(posedge hclk);
    stop_test();
  end
endmodule // clk_switch_tb_top
